// file: iedec_angle.sv
// Sequential angle engine: mechanical angle by restoring division,
// then electrical angle by pole-pair product. Inputs sampled at start.
`default_nettype none
module iedec_angle
	import iedec_pkg::*;
(
	input  wire logic                clk_sys_i,
	input  wire logic                resetn_i,
	input  wire logic [CNT_W-1:0]    count_i,
	input  wire logic [CNT_W-1:0]    ppr_i,
	input  wire logic [ANG_W-1:0]    m_ofs_i,
	input  wire logic [ANG_W-1:0]    e_ofs_i,
	input  wire logic [ANG_W-1:0]    pole_pairs_i,
	output iedec_angles_t            angles_o,
	output logic                     done_o
);
	typedef enum logic [1:0] {ST_LOAD, ST_DIV, ST_MUL} iedec_st_t;

	iedec_st_t        st_r;     // Engine state
	logic [CNT_W-1:0] rem_r;    // Partial remainder
	logic [15:0]      quo_r;    // Quotient bits so far
	logic [4:0]       step_r;   // Division step count
	logic [CNT_W-1:0] cnt_l_r;  // Sampled count
	logic [CNT_W-1:0] ppr_l_r;  // Sampled range
	logic [15:0]      mofs_l_r; // Sampled offsets and pole pairs
	logic [15:0]      eofs_l_r;
	logic [15:0]      pp_l_r;

	// One restoring step
	wire logic [CNT_W:0]   rem_sh = {rem_r, 1'b0};
	wire logic             ge     = rem_sh >= {1'b0, ppr_l_r};
	wire logic [CNT_W:0]   rem_df = rem_sh - {1'b0, ppr_l_r};
	wire logic [15:0]      quo_nx = {quo_r[14:0], ge};
	// Zero range yields quotient zero rather than garbage
	wire logic [15:0]      quo_ok = (ppr_l_r == '0) ? 16'h0000 : quo_r;
	wire logic [15:0]      phi_m  = quo_ok + mofs_l_r; // RULE_10
	wire logic [31:0]      prod   = {16'h0000, phi_m} * {16'h0000, pp_l_r};
	wire logic [15:0]      phi_e  = prod[15:0] + eofs_l_r; // RULE_11

	// Engine sequence
	always_ff @(posedge clk_sys_i) begin
		done_o <= 1'b0;
		if (!resetn_i) begin
			st_r     <= ST_LOAD;
			rem_r    <= '0;
			quo_r    <= '0;
			step_r   <= '0;
			cnt_l_r  <= '0;
			ppr_l_r  <= '0;
			mofs_l_r <= '0;
			eofs_l_r <= '0;
			pp_l_r   <= '0;
			angles_o <= '0;
		end else begin
			unique case (st_r)
				ST_LOAD: begin
					cnt_l_r  <= count_i;
					ppr_l_r  <= ppr_i;
					mofs_l_r <= m_ofs_i;
					eofs_l_r <= e_ofs_i;
					pp_l_r   <= pole_pairs_i; // RULE_12
					rem_r    <= count_i;
					quo_r    <= '0;
					step_r   <= '0;
					st_r     <= ST_DIV;
				end
				ST_DIV: begin
					rem_r  <= ge ? rem_df[CNT_W-1:0] : rem_sh[CNT_W-1:0];
					quo_r  <= quo_nx;
					step_r <= step_r + 5'h01;
					if (step_r == 5'(DIV_STEPS - 1)) begin
						st_r <= ST_MUL;
					end
				end
				ST_MUL: begin
					angles_o <= '{phi_e: phi_e, phi_m: phi_m};
					done_o   <= 1'b1;
					st_r     <= ST_LOAD;
				end
			endcase
		end
	end

	// Reference quotient for checking only
	wire logic [39:0] ref_q = {cnt_l_r, 16'h0000} / {16'h0000, ppr_l_r};
	wire logic [15:0] ref_m = ref_q[15:0] + mofs_l_r;
	wire logic [31:0] ref_p = {16'h0000, ref_m} * {16'h0000, pp_l_r};
	wire logic [15:0] ref_e = ref_p[15:0] + eofs_l_r;

	a_mech_angle: assert property ( // RULE_10
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(st_r == ST_MUL && ppr_l_r != '0 && cnt_l_r < ppr_l_r)
		|=> angles_o.phi_m == $past(ref_m))
		else $error("mechanical angle wrong");
	a_elec_angle: assert property ( // RULE_11
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(st_r == ST_MUL && ppr_l_r != '0 && cnt_l_r < ppr_l_r)
		|=> angles_o.phi_e == $past(ref_e))
		else $error("electrical angle wrong");
endmodule
`default_nettype wire

// file: iedec_enc_model.sv
// Behavioural incremental encoder with index output for the decoder bench.
// Assumes the bench requests one step per clock pulse on step_i.
`default_nettype none
module iedec_enc_model
	import iedec_pkg::*;
(
	input  wire logic       clk_sys_i,
	input  wire logic       resetn_i,
	input  wire logic       step_i,   // One step request
	input  wire logic       back_i,   // Step backwards when high
	input  wire logic       index_i,  // Index level before inversion
	input  wire logic [2:0] invert_i, // Pin inversion: A, B, N
	input  wire logic [3:0] lag_i,    // Clocks from request to edge
	output iedec_abn_t      pins_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] pos_r;  // Phase position 0..3
	logic       pend_r; // Step waiting to be applied
	logic       back_r; // Direction of the waiting step
	logic [3:0] wait_r; // Clocks left before the edge
	// Positions give AB = 00, 10, 11, 01: one pin changes per step
	assign pins_o = {pos_r[0] ^ pos_r[1] ^ invert_i[0],
		pos_r[1] ^ invert_i[1], index_i ^ invert_i[2]};
	// Apply each request after the chosen lag, promptly or slowly
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			pos_r <= 2'h0;
			pend_r <= 1'b0;
			back_r <= 1'b0;
			wait_r <= 4'h0;
		end else if (step_i) begin
			pend_r <= 1'b1;
			back_r <= back_i;
			wait_r <= lag_i;
		end else if (pend_r && wait_r == 4'h0) begin
			// Gray sequence forwards or backwards
			pos_r <= back_r ? pos_r - 2'h1 : pos_r + 2'h1;
			pend_r <= 1'b0;
		end else if (pend_r) begin
			wait_r <= wait_r - 4'h1;
		end
	end
endmodule
`default_nettype wire

// file: iedec_pkg.sv
// Constants, register map and carrier types of the encoder decoder.
// Assumes a single system clock domain and a plain register port.
`default_nettype none
package iedec_pkg;
	// Widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W  = 24;
	localparam int ANG_W  = 16;
	localparam int DIV_STEPS = 16; // Quotient bits of count*2^16/ppr

	// Register offsets
	localparam logic [7:0] IDX_POLE_PAIRS = 8'h1b;
	localparam logic [7:0] IDX_MODE       = 8'h25;
	localparam logic [7:0] IDX_PPR        = 8'h26;
	localparam logic [7:0] IDX_COUNT      = 8'h27;
	localparam logic [7:0] IDX_LATCH      = 8'h28;
	localparam logic [7:0] IDX_OFFSETS    = 8'h29;
	localparam logic [7:0] IDX_ANGLES     = 8'h2a;

	// Mode field positions
	localparam int POS_APOL   = 0;
	localparam int POS_BPOL   = 1;
	localparam int POS_NPOL   = 2;
	localparam int POS_QUAL   = 3;
	localparam int POS_RELOAD = 8;
	localparam int POS_DIR    = 12;
	localparam logic [31:0] MODE_MASK = 32'h0000_110f;

	// Reset values
	localparam logic [31:0] RST_MODE       = 32'h0000_0000;
	localparam logic [23:0] RST_PPR        = 24'h00_1000;
	localparam logic [23:0] RST_COUNT      = 24'h00_0000;
	localparam logic [23:0] RST_LATCH      = 24'h00_0000;
	localparam logic [31:0] RST_OFFSETS    = 32'h0000_0000;
	localparam logic [15:0] RST_POLE_PAIRS = 16'h0001;

	// Decoded mode bits
	typedef struct packed {
		logic dir;
		logic reload;
		logic qualify;
		logic npol;
		logic bpol;
		logic apol;
	} iedec_mode_t;

	// Encoder pins as one group
	typedef struct packed {
		logic a;
		logic b;
		logic n;
	} iedec_abn_t;

	// Angle results, electrical in the upper half
	typedef struct packed {
		logic [15:0] phi_e;
		logic [15:0] phi_m;
	} iedec_angles_t;
endpackage
`default_nettype wire

// file: iedec_top.sv
// Incremental encoder decoder: pin sync, quadrature count, index and
// angle registers. Assumes asynchronous encoder pins, one clock.
//
// Contract
// (RULE_01) Per-input polarity inversion from mode bits 0-2
// (RULE_02) Qualify bit requires index with A and B
// (RULE_03) Index: capture count, or reload from latch
// (RULE_04) Direction bit reverses counting sense
// (RULE_05) Hold 24-bit pulses per revolution setting
// (RULE_06) Count wraps modulo range both directions
// (RULE_07) Software count write; counting continues from it
// (RULE_08) Latched index count held and readable
// (RULE_09) Index clearing count also shows latch zero
// (RULE_10) Mechanical angle: count*2^16/range plus offset
// (RULE_11) Electrical angle: mechanical times pole pairs plus offset
// (RULE_12) Pole pairs from separate motor register
// (RULE_13) One count per valid quadrature edge
// (RULE_14) Encoder inputs synchronised before edge detection
//
// The address-and-strobe port was decided locally.
`default_nettype none
module iedec_top
	import iedec_pkg::*;
#(
	parameter logic [CNT_W-1:0] RST_PPR_P = RST_PPR
) (
	input  wire logic              clk_sys_i,
	input  wire logic              resetn_i,
	input  wire logic              enc_a_i,
	input  wire logic              enc_b_i,
	input  wire logic              enc_n_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	input  wire logic              wr_en_i,
	input  wire logic              rd_en_i,
	output logic      [DATA_W-1:0] rd_data_o,
	output iedec_angles_t          angles_o,
	output logic                   index_event_o
);
	// Checks run on the system clock and rest while reset is held
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	// A zero range cannot serve as the reset setting
	if (RST_PPR_P == '0) begin : g_chk
		$error("RST_PPR_P must be nonzero");
	end

	// Next state in the A,B cycle for forward motion
	// A pair of states two phases apart is a jump and counts nothing
	function automatic logic [1:0] gray_next(input logic [1:0] s);
		unique case (s)
			2'b00: gray_next = 2'b10;
			2'b10: gray_next = 2'b11;
			2'b11: gray_next = 2'b01;
			2'b01: gray_next = 2'b00;
		endcase
	endfunction

	// Count plus one with wrap at range
	function automatic logic [CNT_W-1:0] wrap_inc(
		input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] p);
		if (p == '0) begin
			wrap_inc = c + 24'h00_0001;
		end else if (c >= p - 24'h00_0001) begin
			wrap_inc = '0;
		end else begin
			wrap_inc = c + 24'h00_0001;
		end
	endfunction

	// Count minus one with wrap below zero
	// A count left above the range by a range write folds to the top
	function automatic logic [CNT_W-1:0] wrap_dec(
		input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] p);
		if (p == '0) begin
			wrap_dec = c - 24'h00_0001;
		end else if (c == '0 || c >= p) begin
			wrap_dec = p - 24'h00_0001;
		end else begin
			wrap_dec = c - 24'h00_0001;
		end
	endfunction

	// Registers
	logic [31:0]      mode_r;       // Mode word, masked
	logic [CNT_W-1:0] ppr_r;        // Pulses per revolution
	logic [CNT_W-1:0] count_r;      // Running count
	logic [CNT_W-1:0] latch_r;      // Index latch
	logic [31:0]      offsets_r;    // Electrical and mechanical offsets
	logic [15:0]      pole_pairs_r; // Motor pole pairs
	logic [CNT_W-1:0] count_nxt;
	logic [CNT_W-1:0] latch_nxt;
	logic [31:0]      rd_nxt;

	// Synchroniser and edge history
	iedec_abn_t       sync1_r;      // First stage, read only by stage two
	iedec_abn_t       sync2_r;      // Stable copies of the pins
	logic [1:0]       ab_prev_r;    // Previous polarity-corrected A,B
	logic             nq_prev_r;    // Previous qualified index level
	iedec_angles_t    eng_angles;   // Engine results
	logic             eng_done;     // Engine result strobe

	// Mode fields
	wire iedec_mode_t mode = '{dir: mode_r[POS_DIR],
		reload: mode_r[POS_RELOAD], qualify: mode_r[POS_QUAL],
		npol: mode_r[POS_NPOL], bpol: mode_r[POS_BPOL],
		apol: mode_r[POS_APOL]};

	// Polarity-corrected inputs
	wire logic a_q = sync2_r.a ^ mode.apol; // RULE_01
	wire logic b_q = sync2_r.b ^ mode.bpol; // RULE_01
	wire logic n_q = sync2_r.n ^ mode.npol; // RULE_01
	wire logic [1:0] ab_cur = {a_q, b_q};

	// Index level, optionally gated by A and B
	// The edge is taken on the level, so a held index counts once
	wire logic n_lvl = mode.qualify ? (n_q & a_q & b_q) : n_q; // RULE_02
	wire logic idx_ev = n_lvl & ~nq_prev_r;

	// Quadrature steps
	// A jump over two phases changes both bits and is ignored
	wire logic fwd = (ab_cur != ab_prev_r) &&
		(ab_cur == gray_next(ab_prev_r)); // RULE_13
	wire logic back = (ab_cur != ab_prev_r) &&
		(ab_prev_r == gray_next(ab_cur)); // RULE_13
	wire logic up   = mode.dir ? back : fwd;  // RULE_04
	wire logic down = mode.dir ? fwd : back;  // RULE_04

	// Address decode
	wire logic wr_mode  = wr_en_i && addr_i == IDX_MODE;
	wire logic wr_ppr   = wr_en_i && addr_i == IDX_PPR;
	wire logic wr_count = wr_en_i && addr_i == IDX_COUNT;
	wire logic wr_latch = wr_en_i && addr_i == IDX_LATCH;
	wire logic wr_ofs   = wr_en_i && addr_i == IDX_OFFSETS;
	wire logic wr_pp    = wr_en_i && addr_i == IDX_POLE_PAIRS;

	// Running count: software write, then index reload, then steps
	always_comb begin
		if (wr_count) begin
			count_nxt = wr_data_i[CNT_W-1:0]; // RULE_07
		end else if (idx_ev && mode.reload) begin
			count_nxt = latch_r; // RULE_03 RULE_09
		end else if (up) begin
			count_nxt = wrap_inc(count_r, ppr_r); // RULE_06
		end else if (down) begin
			count_nxt = wrap_dec(count_r, ppr_r); // RULE_06
		end else begin
			count_nxt = count_r;
		end
	end

	// Latch: index capture wins over a software write
	// The write is lost then; the capture is the fresher data
	always_comb begin
		if (idx_ev && !mode.reload) begin
			latch_nxt = count_r; // RULE_03 RULE_08
		end else if (wr_latch) begin
			latch_nxt = wr_data_i[CNT_W-1:0];
		end else begin
			latch_nxt = latch_r;
		end
	end

	// Read mux; unmapped offsets read zero
	// Angles come from the output copy, never from a half result
	always_comb begin
		unique case (addr_i)
			IDX_MODE:       rd_nxt = mode_r;
			IDX_PPR:        rd_nxt = {8'h00, ppr_r};
			IDX_COUNT:      rd_nxt = {8'h00, count_r};
			IDX_LATCH:      rd_nxt = {8'h00, latch_r}; // RULE_08
			IDX_OFFSETS:    rd_nxt = offsets_r;
			IDX_ANGLES:     rd_nxt = angles_o;
			IDX_POLE_PAIRS: rd_nxt = {16'h0000, pole_pairs_r};
			default:        rd_nxt = 32'h0000_0000;
		endcase
	end

	// Pin synchronisers
	// Stage one feeds only stage two, so metastability stays there
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= '{a: enc_a_i, b: enc_b_i, n: enc_n_i}; // RULE_14
			sync2_r <= sync1_r; // RULE_14
		end
	end

	// Edge history
	// Reset to idle levels; a pin high at release looks like an edge
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			ab_prev_r     <= '0;
			nq_prev_r     <= 1'b0;
			index_event_o <= 1'b0;
		end else begin
			ab_prev_r     <= ab_cur;
			nq_prev_r     <= n_lvl;
			index_event_o <= idx_ev;
		end
	end

	// Configuration registers
	// A polarity or qualify change can raise one index event, so
	// software should change them with the encoder at rest
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			mode_r       <= RST_MODE;
			ppr_r        <= RST_PPR_P;
			offsets_r    <= RST_OFFSETS;
			pole_pairs_r <= RST_POLE_PAIRS;
		end else begin
			if (wr_mode) mode_r <= wr_data_i & MODE_MASK;
			if (wr_ppr) ppr_r <= wr_data_i[CNT_W-1:0]; // RULE_05
			if (wr_ofs) offsets_r <= wr_data_i;
			if (wr_pp) pole_pairs_r <= wr_data_i[15:0]; // RULE_12
		end
	end

	// Count, latch, read data and angle copy
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			count_r   <= RST_COUNT;
			latch_r   <= RST_LATCH;
			rd_data_o <= '0;
			angles_o  <= '0;
		end else begin
			count_r   <= count_nxt;
			latch_r   <= latch_nxt;
			rd_data_o <= rd_en_i ? rd_nxt : 32'h0000_0000;
			if (eng_done) angles_o <= eng_angles;
		end
	end

	// Angle engine
	// Runs freely; results lag the count by up to two passes
	iedec_angle u_angle (
		.clk_sys_i    (clk_sys_i),
		.resetn_i     (resetn_i),
		.count_i      (count_r),
		.ppr_i        (ppr_r),
		.m_ofs_i      (offsets_r[15:0]),
		.e_ofs_i      (offsets_r[31:16]),
		.pole_pairs_i (pole_pairs_r),
		.angles_o     (eng_angles),
		.done_o       (eng_done)
	);

	// Pin path: two-stage delay, then polarity
	a_sync_two_ff: assert property (##2 1 |-> // RULE_14
		sync2_r.a == $past(enc_a_i, 2))
		else $error("A pin not delayed two cycles");
	a_pol_apply: assert property (##2 1 |-> // RULE_01
		b_q == ($past(enc_b_i, 2) ^ mode_r[POS_BPOL]))
		else $error("B polarity not applied");

	// Index qualification, capture, reload and pulse
	a_qual_gate: assert property (idx_ev && mode.qualify |-> // RULE_02
		a_q && b_q && n_q)
		else $error("qualified index without A and B");
	a_idx_capture: assert property (idx_ev && !mode.reload |=> // RULE_03
		latch_r == $past(count_r))
		else $error("index capture missing");
	a_idx_reload: assert property ( // RULE_09
		idx_ev && mode.reload && !wr_count
		|=> count_r == $past(latch_r))
		else $error("index reload missing");
	a_idx_pulse: assert property (idx_ev |=> index_event_o)
		else $error("index pulse missing");
	a_latch_hold: assert property (!idx_ev && !wr_latch |=> // RULE_08
		latch_r == $past(latch_r))
		else $error("latch changed without cause");

	// Running count: software write, steps and range
	a_sw_write: assert property (wr_count |=> // RULE_07
		{8'h00, count_r} == ($past(wr_data_i) & 32'h00ff_ffff))
		else $error("count write lost");
	a_count_up: assert property ( // RULE_13
		fwd && !mode.dir && !wr_count && !idx_ev
		|=> count_r == wrap_inc($past(count_r), $past(ppr_r)))
		else $error("forward step wrong");
	a_count_down: assert property ( // RULE_04
		fwd && mode.dir && !wr_count && !idx_ev
		|=> count_r == wrap_dec($past(count_r), $past(ppr_r)))
		else $error("reversed step wrong");
	a_count_back: assert property ( // RULE_13
		back && !mode.dir && !wr_count && !idx_ev
		|=> count_r == wrap_dec($past(count_r), $past(ppr_r)))
		else $error("backward step wrong");
	a_range_keep: assert property ( // RULE_06
		ppr_r != '0 && count_r < ppr_r && !wr_count && !wr_ppr &&
		!(idx_ev && mode.reload) |=> count_r < ppr_r)
		else $error("count left its range");

	// Read data stands only in the slot after a read strobe
	a_read_slot: assert property (!rd_en_i |=> rd_data_o == '0)
		else $error("read data outside its slot");

	// Main scenarios
	c_idx_capture: cover property (idx_ev && !mode.reload);
	c_idx_reload: cover property (idx_ev && mode.reload);
	c_qual_idx: cover property (idx_ev && mode.qualify);
	c_wrap_up: cover property (up && count_r == ppr_r - 24'h00_0001);
	c_wrap_down: cover property (down && count_r == '0);
endmodule
`default_nettype wire

// file: placeholder_end.sv
// Empty compilation unit; holds no logic.
// Assumes nothing of its surroundings.
`default_nettype none
`default_nettype wire

// file: tb_incremental_encoder_decoder.sv
// Self-checking bench for the encoder decoder top with an encoder model.
// Assumes one 10 MHz clock and the plain register port of the design.
`default_nettype none
module tb_incremental_encoder_decoder
	import iedec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic          clk_sys_i = 1'b0; // System clock
	logic          resetn_i  = 1'b0; // Active low reset
	logic [7:0]    addr_i    = 8'h00; // Register index
	logic [31:0]   wr_data_i = 32'h0; // Write data
	logic          wr_en_i   = 1'b0; // Write strobe
	logic          rd_en_i   = 1'b0; // Read strobe
	logic [31:0]   rd_data_o;         // Read data
	iedec_angles_t angles_o;          // Angle outputs
	logic          index_event_o;     // Index pulse
	logic          step_i    = 1'b0; // Model step request
	logic          back_i    = 1'b0; // Model step direction
	logic          index_i   = 1'b0; // Model index level
	logic [2:0]    invert_i  = 3'h0; // Model pin inversion
	logic [3:0]    lag_i     = 4'h0; // Model step lag
	iedec_abn_t    pins;              // Encoder pins
	int            num_errors = 0;    // Mismatches
	int            num_checks = 0;    // Comparisons
	int            ev_cnt     = 0;    // Index pulses seen
	int            base;              // Pulse count baseline
	// Clock of 100 ns period
	always #50 clk_sys_i = ~clk_sys_i;
	// Count index pulses
	always @(posedge clk_sys_i) begin
		if (index_event_o === 1'b1) begin
			ev_cnt <= ev_cnt + 1;
		end
	end
	iedec_enc_model enc (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.step_i(step_i), .back_i(back_i), .index_i(index_i),
		.invert_i(invert_i), .lag_i(lag_i), .pins_o(pins));
	iedec_top uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.enc_a_i(pins.a), .enc_b_i(pins.b), .enc_n_i(pins.n),
		.addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
		.rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .angles_o(angles_o),
		.index_event_o(index_event_o));
	// Compare and count
	task automatic check(input string what, input logic [31:0] got,
		input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Verdict and end of run
	task automatic tally_and_finish();
		if (num_errors == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// One-cycle register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		wr_en_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_sys_i);
		wr_en_i <= 1'b0;
	endtask
	// Register read, data taken in the following cycle
	task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		rd_en_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_en_i <= 1'b0;
		#1;
		check($sformatf("reg %h", a), rd_data_o, e);
	endtask
	// One encoder step, then time for sync and count
	task automatic step(input logic b);
		@(posedge clk_sys_i);
		step_i <= 1'b1;
		back_i <= b;
		@(posedge clk_sys_i);
		step_i <= 1'b0;
		repeat (int'(lag_i) + 8) @(posedge clk_sys_i);
	endtask
	// Index pulse of six clocks
	task automatic pulse_index();
		@(posedge clk_sys_i);
		index_i <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		index_i <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
	endtask
	// Reset values, write mask, read-only and unmapped places
	task automatic t_reset_map();
		expect_reg(IDX_MODE, 32'h0);
		expect_reg(IDX_PPR, 32'(RST_PPR));
		expect_reg(IDX_COUNT, 32'h0);
		expect_reg(IDX_LATCH, 32'h0);
		expect_reg(IDX_POLE_PAIRS, 32'h1);
		wr(IDX_MODE, 32'hffff_ffff);
		expect_reg(IDX_MODE, MODE_MASK);
		wr(IDX_MODE, 32'h0);
		wr(IDX_ANGLES, 32'h1234_5678);
		expect_reg(IDX_ANGLES, 32'h0);
		expect_reg(8'h30, 32'h0);
	endtask
	// Wrap both ways, software count, direction bit
	task automatic t_count();
		wr(IDX_PPR, 32'h4);
		wr(IDX_COUNT, 32'h3);
		step(1'b0);
		expect_reg(IDX_COUNT, 32'h0);
		lag_i <= 4'h5;
		step(1'b1);
		expect_reg(IDX_COUNT, 32'h3);
		lag_i <= 4'h0;
		wr(IDX_MODE, 32'h1000);
		step(1'b0);
		expect_reg(IDX_COUNT, 32'h2);
		wr(IDX_MODE, 32'h0);
	endtask
	// Inverted encoder pins with matching polarity bits
	task automatic t_polarity();
		wr(IDX_MODE, 32'h7);
		invert_i <= 3'h7;
		step(1'b0);
		expect_reg(IDX_COUNT, 32'h3);
		wr(IDX_LATCH, 32'h55);
		base = ev_cnt;
		pulse_index();
		check("pulses", 32'(ev_cnt - base), 32'h1);
		expect_reg(IDX_LATCH, 32'h3);
		wr(IDX_MODE, 32'h0);
		invert_i <= 3'h0;
	endtask
	// Reload from latch, clearing to zero, counting on from it
	task automatic t_reload();
		wr(IDX_MODE, 32'h100);
		wr(IDX_LATCH, 32'h1);
		pulse_index();
		expect_reg(IDX_COUNT, 32'h1);
		wr(IDX_LATCH, 32'h0);
		pulse_index();
		expect_reg(IDX_COUNT, 32'h0);
		expect_reg(IDX_LATCH, 32'h0);
		step(1'b0);
		expect_reg(IDX_COUNT, 32'h1);
		wr(IDX_MODE, 32'h0);
	endtask
	// Index qualified by A and B
	task automatic t_qualify();
		wr(IDX_MODE, 32'h8);
		base = ev_cnt;
		pulse_index();
		check("unqualified", 32'(ev_cnt - base), 32'h0);
		step(1'b1);
		wr(IDX_LATCH, 32'h55);
		pulse_index();
		check("qualified", 32'(ev_cnt - base), 32'h1);
		expect_reg(IDX_LATCH, 32'h0);
		wr(IDX_MODE, 32'h0);
	endtask
	// Mechanical and electrical angle with offsets
	task automatic t_angles();
		int n;
		wr(IDX_PPR, 32'h4);
		wr(IDX_COUNT, 32'h1);
		wr(IDX_OFFSETS, 32'h0100_0010);
		wr(IDX_POLE_PAIRS, 32'h3);
		n = 0;
		while (angles_o !== 32'hc130_4010 && n < 200) begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end
		check("angles", angles_o, 32'hc130_4010);
		expect_reg(IDX_ANGLES, 32'hc130_4010);
	endtask
	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		num_errors++;
		tally_and_finish();
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		t_reset_map();
		t_count();
		t_polarity();
		t_reload();
		t_qualify();
		t_angles();
		tally_and_finish();
	end
endmodule
`default_nettype wire
